// file: core/pbc_ctrl_reg.sv
/*
  Basic PHY control register with its management frame access, soft reset
  sequencing and the effective mode outputs it steers.
  Assumes auto-negotiation results, medium loopback and the nibble paths
  come from logic on sys_clk_i; management and power-down pins are async.
*/
// Function
// - Host reads and writes PHY registers through management frames.
// - Writing one to bit 15 restores defaults, then bit clears itself.
// - Bit 15 reads one during soft reset; accesses resume afterwards.
// - Bit 14 loops transmit nibbles back into the receive path.
// - In loopback the receive path is cut off from the line.
// - Control loopback bit overrides the medium-side loopback bit.
// - Without auto-negotiation bit 13 forces speed; it always reads back.
// - With auto-negotiation on, forced speed and duplex bits are ignored.
// - Bit 11 enters low power; clearing it returns to normal.
// - Bit 10 isolates the media-independent interface both directions.
// - Writing one to bit 9 restarts auto-negotiation, then self-clears.
// - Without auto-negotiation bit 8 selects half or full duplex.
// - With auto-negotiation on, duplex bit reads one and ignores writes.
// - In loopback, behaviour does not depend on the duplex bit.
// - Bit 7 does nothing, resets to one and stays writable.
// - Low-power bit is ORed with the host-link power-down control.
`timescale 1ns/100ps
`default_nettype none

module pbc_ctrl_reg
  import pbc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        mgmt_clk_i,
  input  wire logic        mgmt_data_i,
  output logic             mgmt_data_o,
  output logic             mgmt_data_oe_n_o,
  input  wire logic        host_power_down_i,
  input  wire logic        medium_loopback_i,
  input  wire logic        an_speed_100_i,
  input  wire logic        an_full_duplex_i,
  input  wire pbc_nib_type host_tx_i,
  input  wire pbc_nib_type line_rx_i,
  output pbc_nib_type      host_rx_o,
  output pbc_nib_type      line_tx_o,
  output logic             soft_reset_o,
  output logic             an_restart_o,
  output logic             an_enable_o,
  output logic             speed_100_o,
  output logic             full_duplex_o,
  output logic             low_power_o,
  output logic             nibble_loopback_o,
  output logic             medium_loopback_o,
  output logic             line_rx_isolate_o,
  output logic             mii_isolate_o
);

  localparam int RST_WAIT = SOFT_RESET_CYCLES;
  localparam int RST_LAST = SOFT_RESET_CYCLES - 1;

  pbc_mgmt_req_type   req;
  pbc_ctrl_state_type state_q, state_d;
  logic [7:0]         cnt_q, cnt_d;
  logic [15:0]        ctrl_q, ctrl_d;
  logic [15:0]        rd_q, rd_d;
  logic               restart_q, restart_d;
  logic               busy_q, busy_d;
  logic               hpd_s1_q, hpd_s2_q;
  logic               spd_q, spd_d, dup_q, dup_d, pwr_q, pwr_d;
  logic               mlb_q, mlb_d, lris_q, lris_d;
  pbc_nib_type        hrx_q, hrx_d, ltx_q, ltx_d;
  logic               ctrl_hit;

  // Value seen by a read: self-clearing and reserved bits folded in
  function automatic logic [15:0] ctrl_view(input logic [15:0] c, input logic busy);
    logic [15:0] v;
    v = c;
    v[CTRL_RESET_BIT]   = busy;
    v[CTRL_RESTART_BIT] = 1'b0;
    if (c[CTRL_ANE_BIT]) begin
      v[CTRL_DUPLEX_BIT] = 1'b1;
    end
    v[CTRL_RSVD_MSB:0] = '0;
    return v;
  endfunction

  // Merge a host write; duplex is frozen while auto-negotiation is on
  function automatic logic [15:0] ctrl_merge(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] m;
    m = '0;
    m[CTRL_LOOP_BIT:CTRL_ISO_BIT] = w[CTRL_LOOP_BIT:CTRL_ISO_BIT];
    m[CTRL_DUPLEX_BIT] = c[CTRL_ANE_BIT] ? c[CTRL_DUPLEX_BIT]
                                         : w[CTRL_DUPLEX_BIT];
    m[CTRL_COLTEST_BIT] = w[CTRL_COLTEST_BIT];
    return m;
  endfunction

  pbc_mgmt_frame u_frame (
    .sys_clk_i        (sys_clk_i),
    .reset_i          (reset_i),
    .mgmt_clk_i       (mgmt_clk_i),
    .mgmt_data_i      (mgmt_data_i),
    .rd_data_i        (rd_q),
    .req_o            (req),
    .mgmt_data_o      (mgmt_data_o),
    .mgmt_data_oe_n_o (mgmt_data_oe_n_o)
  );

  assign ctrl_hit = req.addr == CTRL_REG_ADDR;

  // Register access and soft reset sequencing
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    ctrl_d    = ctrl_q;
    restart_d = 1'b0;
    rd_d      = rd_q;
    if (req.rd) begin
      // Other register addresses belong to neighbouring blocks; read as zero here
      rd_d = ctrl_hit ? ctrl_view(ctrl_q, busy_q) : '0;
    end
    case (state_q)
      CT_RUN: begin
        if (req.wr && ctrl_hit) begin
          if (req.data[CTRL_RESET_BIT]) begin
            // Reset wins over every other bit of the same write
            state_d = CT_RESET;
            cnt_d   = SOFT_RESET_LOAD;
            ctrl_d  = CTRL_RESET_VAL;
          end else begin
            ctrl_d    = ctrl_merge(ctrl_q, req.data);
            restart_d = req.data[CTRL_RESTART_BIT];
          end
        end
      end
      CT_RESET: begin
        // Writes are dropped until the reset completes
        if (cnt_q == '0) begin
          state_d = CT_RUN;
          ctrl_d  = CTRL_RESET_VAL;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: state_d = CT_RUN;
    endcase
    busy_d = state_d == CT_RESET;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q   <= CT_RUN;
      cnt_q     <= '0;
      ctrl_q    <= CTRL_RESET_VAL;
      rd_q      <= '0;
      restart_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      ctrl_q    <= ctrl_d;
      rd_q      <= rd_d;
      restart_q <= restart_d;
      busy_q    <= busy_d;
    end
  end

  // Power-down pin from the host link comes from another domain
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hpd_s1_q <= 1'b0;
      hpd_s2_q <= 1'b0;
    end else begin
      hpd_s1_q <= host_power_down_i;
      hpd_s2_q <= hpd_s1_q;
    end
  end

  // Effective modes and the nibble paths; all registered so outputs are clean
  always_comb begin
    spd_d = ctrl_q[CTRL_ANE_BIT] ? an_speed_100_i : ctrl_q[CTRL_SPEED_BIT];
    if (ctrl_q[CTRL_LOOP_BIT]) begin
      dup_d = 1'b1;
    end else if (ctrl_q[CTRL_ANE_BIT]) begin
      dup_d = an_full_duplex_i;
    end else begin
      dup_d = ctrl_q[CTRL_DUPLEX_BIT];
    end
    pwr_d  = ctrl_q[CTRL_PDOWN_BIT] | hpd_s2_q;
    mlb_d  = medium_loopback_i & ~ctrl_q[CTRL_LOOP_BIT];
    lris_d = ctrl_q[CTRL_LOOP_BIT];
    // Isolation cuts both directions; loopback keeps line traffic out
    if (ctrl_q[CTRL_ISO_BIT]) begin
      hrx_d = '0;
      ltx_d = '0;
    end else if (ctrl_q[CTRL_LOOP_BIT]) begin
      hrx_d = host_tx_i;
      ltx_d = '0;
    end else begin
      hrx_d = line_rx_i;
      ltx_d = host_tx_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spd_q  <= 1'b0;
      dup_q  <= 1'b0;
      pwr_q  <= 1'b0;
      mlb_q  <= 1'b0;
      lris_q <= 1'b0;
      hrx_q  <= '0;
      ltx_q  <= '0;
    end else begin
      spd_q  <= spd_d;
      dup_q  <= dup_d;
      pwr_q  <= pwr_d;
      mlb_q  <= mlb_d;
      lris_q <= lris_d;
      hrx_q  <= hrx_d;
      ltx_q  <= ltx_d;
    end
  end

  // Bit 7 drives nothing; it is only stored and read back
  assign soft_reset_o      = busy_q;
  assign an_restart_o      = restart_q;
  assign an_enable_o       = ctrl_q[CTRL_ANE_BIT];
  assign speed_100_o       = spd_q;
  assign full_duplex_o     = dup_q;
  assign low_power_o       = pwr_q;
  assign nibble_loopback_o = ctrl_q[CTRL_LOOP_BIT];
  assign medium_loopback_o = mlb_q;
  assign line_rx_isolate_o = lris_q;
  assign mii_isolate_o     = ctrl_q[CTRL_ISO_BIT];
  assign host_rx_o         = hrx_q;
  assign line_tx_o         = ltx_q;

  // Soft reset lasts exactly the programmed number of cycles
  soft_reset_len_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(soft_reset_o) |-> ##RST_LAST soft_reset_o ##1 !soft_reset_o
      && ctrl_q == CTRL_RESET_VAL)
    else $error("soft reset length or defaults wrong");

  // Defaults are loaded on entry, so the register must sit at them throughout
  reset_reads_one_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    soft_reset_o |-> ctrl_q == CTRL_RESET_VAL
      && (!(req.rd && ctrl_hit) || rd_d[CTRL_RESET_BIT]))
    else $error("register not at defaults or bit 15 low during soft reset");

  loop_path_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_LOOP_BIT] && !ctrl_q[CTRL_ISO_BIT] |=> host_rx_o == $past(host_tx_i))
    else $error("loopback data not returned");

  line_cut_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_LOOP_BIT] |=> line_rx_isolate_o && line_tx_o == '0)
    else $error("line not isolated in loopback");

  loop_priority_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_LOOP_BIT] |=> !medium_loopback_o)
    else $error("medium loopback active under control loopback");

  forced_speed_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !ctrl_q[CTRL_ANE_BIT] |=> speed_100_o == $past(ctrl_q[CTRL_SPEED_BIT]))
    else $error("forced speed not applied");

  an_speed_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_ANE_BIT] |=> speed_100_o == $past(an_speed_100_i))
    else $error("auto-negotiated speed not applied");

  low_power_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_PDOWN_BIT] |=> low_power_o)
    else $error("low power bit ignored");

  pin_power_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    hpd_s2_q |=> low_power_o)
    else $error("host power-down ignored");

  mii_cut_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_ISO_BIT] |=> host_rx_o == '0 && line_tx_o == '0)
    else $error("interface not isolated");

  restart_pulse_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    an_restart_o |=> !an_restart_o)
    else $error("restart did not self-clear");

  forced_duplex_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !ctrl_q[CTRL_ANE_BIT] && !ctrl_q[CTRL_LOOP_BIT]
      |=> full_duplex_o == $past(ctrl_q[CTRL_DUPLEX_BIT]))
    else $error("forced duplex not applied");

  duplex_ro_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_ANE_BIT] && !soft_reset_o && !busy_d |=> $stable(ctrl_q[CTRL_DUPLEX_BIT]))
    else $error("duplex bit written under auto-negotiation");

  loop_duplex_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctrl_q[CTRL_LOOP_BIT] |=> full_duplex_o)
    else $error("duplex depends on bit 8 in loopback");

  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    req.rd && ctrl_hit |=> rd_q[CTRL_RSVD_MSB:0] == '0)
    else $error("reserved bits read non-zero");

endmodule

`default_nettype wire

// file: core/pbc_pkg.sv
/*
  Shared constants and types for the basic PHY control register block:
  bit positions, reset value, management frame layout, soft reset time.
  Assumes a single 10 MHz system clock; no other package is required.
*/
package pbc_pkg;

  // Clock and soft reset timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SOFT_RESET_NS     = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SOFT_RESET_LOAD = 8'(SOFT_RESET_CYCLES - 1);

  // Register map and control field positions
  localparam logic [4:0] CTRL_REG_ADDR   = 5'h00;
  localparam logic [4:0] PHY_ADDR        = 5'h01; // Arbitrary management address
  localparam int CTRL_RESET_BIT   = 15;
  localparam int CTRL_LOOP_BIT    = 14;
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_ANE_BIT     = 12;
  localparam int CTRL_PDOWN_BIT   = 11;
  localparam int CTRL_ISO_BIT     = 10;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_COLTEST_BIT = 7;
  localparam int CTRL_RSVD_MSB    = 6;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3080;

  // Management frame layout (bits counted on the rising management clock)
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HDR_LAST      = 6'h0c;
  localparam logic [5:0] TA_LAST       = 6'h01;
  localparam logic [5:0] DATA_LAST     = 6'h0f;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;

  // One register access taken from a management frame
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] data;
  } pbc_mgmt_req_type;

  // One nibble of the media-independent data path
  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } pbc_nib_type;

  typedef enum logic [1:0] {FR_PRE, FR_HDR, FR_TA, FR_DATA} pbc_frame_state_type;
  typedef enum logic {CT_RUN, CT_RESET} pbc_ctrl_state_type;

endpackage

// file: core/pbc_mgmt_frame.sv
/*
  Management frame engine: samples the serial management clock and data
  pins, decodes read and write frames for this PHY and drives read data.
  Assumes the management clock runs at most a quarter of sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module pbc_mgmt_frame
  import pbc_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             mgmt_clk_i,
  input  wire logic             mgmt_data_i,
  input  wire logic [15:0]      rd_data_i,
  output pbc_mgmt_req_type      req_o,
  output logic                  mgmt_data_o,
  output logic                  mgmt_data_oe_n_o
);

  logic                clk_s1_q, clk_s2_q, clk_s3_q;
  logic                dat_s1_q, dat_s2_q;
  pbc_frame_state_type state_q, state_d;
  logic [5:0]          cnt_q, cnt_d;
  logic [15:0]         sh_q, sh_d;
  logic [12:0]         hdr_q, hdr_d;
  logic                rdop_q, rdop_d, wrop_q, wrop_d;
  logic [4:0]          addr_q, addr_d;
  pbc_mgmt_req_type    req_q, req_d;
  logic                out_q, out_d, oe_n_q, oe_n_d;
  logic                rise;
  logic                bit_in;
  logic [12:0]         hdr_full;

  // Pin synchronisers; the second stages feed logic, and the third clock stage feeds edge detection
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else begin
      clk_s1_q <= mgmt_clk_i;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= mgmt_data_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign rise     = clk_s2_q & ~clk_s3_q;
  assign bit_in   = dat_s2_q;
  assign hdr_full = {hdr_q[11:0], bit_in};

  // Frame sequencing; outputs change just after a rising edge so the host
  // sees them settled at the next one
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    hdr_d   = hdr_q;
    rdop_d  = rdop_q;
    wrop_d  = wrop_q;
    addr_d  = addr_q;
    out_d   = out_q;
    oe_n_d  = oe_n_q;
    req_d   = '0;
    if (rise) begin
      case (state_q)
        FR_PRE: begin
          if (bit_in) begin
            cnt_d = (cnt_q == PREAMBLE_BITS) ? cnt_q : cnt_q + 6'h01;
          end else if (cnt_q == PREAMBLE_BITS) begin
            state_d = FR_HDR;
            cnt_d   = '0;
          end else begin
            cnt_d = '0;
          end
        end
        FR_HDR: begin
          hdr_d = hdr_full;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == HDR_LAST) begin
            // Start bit, opcode, PHY address, register address
            addr_d  = hdr_full[4:0];
            rdop_d  = hdr_full[12] && hdr_full[11:10] == OP_READ
                      && hdr_full[9:5] == PHY_ADDR;
            wrop_d  = hdr_full[12] && hdr_full[11:10] == OP_WRITE
                      && hdr_full[9:5] == PHY_ADDR;
            req_d.rd   = rdop_d;
            req_d.addr = hdr_full[4:0];
            state_d = FR_TA;
            cnt_d   = '0;
          end
        end
        FR_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q != TA_LAST) begin
            out_d  = 1'b0;
            oe_n_d = ~rdop_q;
          end else begin
            // Read data was latched by the register bank two frame bits ago, at the end of the header
            sh_d    = {rd_data_i[14:0], 1'b0};
            out_d   = rd_data_i[15];
            state_d = FR_DATA;
            cnt_d   = '0;
          end
        end
        FR_DATA: begin
          sh_d  = {sh_q[14:0], bit_in};
          out_d = sh_q[15];
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == DATA_LAST) begin
            oe_n_d     = 1'b1;
            out_d      = 1'b1;
            req_d.wr   = wrop_q;
            req_d.addr = addr_q;
            req_d.data = {sh_q[14:0], bit_in};
            state_d    = FR_PRE;
            cnt_d      = '0;
          end
        end
        default: state_d = FR_PRE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= FR_PRE;
      cnt_q   <= '0;
      sh_q    <= '0;
      hdr_q   <= '0;
      rdop_q  <= 1'b0;
      wrop_q  <= 1'b0;
      addr_q  <= '0;
      req_q   <= '0;
      out_q   <= 1'b1;
      oe_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      hdr_q   <= hdr_d;
      rdop_q  <= rdop_d;
      wrop_q  <= wrop_d;
      addr_q  <= addr_d;
      req_q   <= req_d;
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign req_o            = req_q;
  assign mgmt_data_o      = out_q;
  assign mgmt_data_oe_n_o = oe_n_q;

  // The pin is only driven while this PHY answers a read
  frame_drive_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !mgmt_data_oe_n_o |-> rdop_q)
    else $error("management data driven outside a read");

endmodule

`default_nettype wire

// file: sim/pbc_host_model.sv
/*
  Host MAC model: issues management frames on the serial clock and data pins.
  Assumes a pull-up on the data line and a PHY that samples on the rising clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pbc_host_model
  import pbc_pkg::*;
(
  output logic      mgmt_clk_o,
  output logic      mgmt_data_o,
  input  wire logic phy_data_i,
  input  wire logic phy_oe_n_i
);
  logic host_oe;
  logic host_bit;

  // Resolved data line; the pull-up wins when nobody drives it
  assign mgmt_data_o = !phy_oe_n_i ? phy_data_i : (host_oe ? host_bit : 1'h1);

  // Clock stands low between frames
  initial begin
    mgmt_clk_o = 1'h0;
    host_oe    = 1'h0;
    host_bit   = 1'h1;
  end

  // One frame at an 800 ns period; data changes only while the clock is low
  task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, input logic raw, output logic [15:0] rdat);
    logic [63:0] fr;
    fr = {32'hffff_ffff, 2'h1, rd ? OP_READ : OP_WRITE, phy, rg, 2'h2,
          raw ? wd : (wd & 16'hff80)};
    rdat = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      host_oe  = !(rd && i < 18); // Turnaround and read data left to the PHY
      host_bit = fr[i];
      #400 mgmt_clk_o = 1'h1;
      if (rd && i < 16) rdat[i] = mgmt_data_o;
      #400 mgmt_clk_o = 1'h0;
    end
    host_oe = 1'h0;
  endtask
endmodule

`default_nettype wire

// file: sim/phy_basic_control_register_tb_top.sv
/*
  Testbench for the basic PHY control register: register accesses through
  host frames, checks of register values and of the mode outputs.
  Assumes pbc_pkg, pbc_ctrl_reg and pbc_host_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module phy_basic_control_register_tb_top
  import pbc_pkg::*;
;
  logic        sys_clk_i = 1'h0;
  logic        reset_i;
  logic        mgmt_clk, mgmt_data, phy_data, phy_oe_n;
  logic        host_power_down, medium_loopback, an_speed_100, an_full_duplex;
  pbc_nib_type host_tx, line_rx, host_rx, line_tx;
  logic        soft_reset, an_restart, an_enable, speed_100, full_duplex;
  logic        low_power, nib_loop, med_loop, rx_iso, mii_iso;
  logic [15:0] rd_v;
  int          errors = 0;
  int          num_checks = 0;
  int          n_restart = 0;
  int          n_srst = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  pbc_ctrl_reg dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .mgmt_clk_i(mgmt_clk),
    .mgmt_data_i(mgmt_data), .mgmt_data_o(phy_data), .mgmt_data_oe_n_o(phy_oe_n),
    .host_power_down_i(host_power_down), .medium_loopback_i(medium_loopback),
    .an_speed_100_i(an_speed_100), .an_full_duplex_i(an_full_duplex),
    .host_tx_i(host_tx), .line_rx_i(line_rx), .host_rx_o(host_rx), .line_tx_o(line_tx),
    .soft_reset_o(soft_reset), .an_restart_o(an_restart), .an_enable_o(an_enable),
    .speed_100_o(speed_100), .full_duplex_o(full_duplex), .low_power_o(low_power),
    .nibble_loopback_o(nib_loop), .medium_loopback_o(med_loop),
    .line_rx_isolate_o(rx_iso), .mii_isolate_o(mii_iso));

  pbc_host_model host (
    .mgmt_clk_o(mgmt_clk), .mgmt_data_o(mgmt_data),
    .phy_data_i(phy_data), .phy_oe_n_i(phy_oe_n));

  // Counts restart pulses and soft reset cycles as they happen
  always @(posedge sys_clk_i) begin
    if (an_restart === 1'h1) n_restart++;
    if (soft_reset === 1'h1) n_srst++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Leaves time for synchronisers and the register update, ends off the edge
  task automatic settle;
    repeat (10) @(posedge sys_clk_i);
    #10;
  endtask

  task automatic wr(input logic [15:0] d, input logic raw);
    host.xfer(1'h0, PHY_ADDR, CTRL_REG_ADDR, d, raw, rd_v);
    settle();
  endtask

  task automatic rd(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
    host.xfer(1'h1, phy, rg, 16'h0000, 1'h0, rd_v);
    settle();
    chk("read data", exp, rd_v);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: about 25 frames of 52 us each should need far less than this
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    errors++;
    print_verdict();
  end

  initial begin
    reset_i = 1'h1;
    host_power_down = 1'h0;
    medium_loopback = 1'h0;
    an_speed_100 = 1'h0;
    an_full_duplex = 1'h0;
    host_tx = '{en: 1'h1, data: 4'ha};
    line_rx = '{en: 1'h1, data: 4'h5};
    repeat (12) @(posedge sys_clk_i);
    #10 reset_i = 1'h0;
    settle();
    // Defaults, with the forced speed bit set but overruled
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h3180);
    chk1("an_enable", 1'h1, an_enable);
    chk1("speed an", 1'h0, speed_100);
    chk1("duplex an", 1'h0, full_duplex);
    // Forced 10 half duplex disagrees with the negotiated 100 full result on purpose
    an_speed_100 = 1'h1;
    an_full_duplex = 1'h1;
    wr(16'h0000, 1'h0);
    chk1("speed 10", 1'h0, speed_100);
    chk1("half duplex", 1'h0, full_duplex);
    wr(16'h2100, 1'h0);
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h2100);
    chk1("speed 100", 1'h1, speed_100);
    chk1("full duplex", 1'h1, full_duplex);
    wr(16'h1000, 1'h0);
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h1100);
    // Duplex written as one while auto-negotiation is still on must not stick
    wr(16'h0100, 1'h0);
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h0000);
    // Reserved bits dirty in the write, bit 7 written back to one
    wr(16'h00ff, 1'h1);
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h0080);
    // Low power from the register and from the host pin
    wr(16'h0800, 1'h0);
    chk1("low power reg", 1'h1, low_power);
    wr(16'h0000, 1'h0);
    chk1("low power off", 1'h0, low_power);
    host_power_down = 1'h1;
    settle();
    chk1("low power pin", 1'h1, low_power);
    host_power_down = 1'h0;
    // Isolation cuts both nibble directions
    wr(16'h0400, 1'h0);
    chk1("isolate", 1'h1, mii_iso);
    chk("host rx iso", 16'h0000, 16'(host_rx));
    chk("line tx iso", 16'h0000, 16'(line_tx));
    wr(16'h0000, 1'h0);
    chk("host rx", 16'h0015, 16'(host_rx));
    chk("line tx", 16'h001a, 16'(line_tx));
    // Loopback with the medium-side request also raised and duplex at zero
    medium_loopback = 1'h1;
    settle();
    chk1("med loop", 1'h1, med_loop);
    wr(16'h4000, 1'h0);
    chk1("nib loop", 1'h1, nib_loop);
    chk1("med loop ovr", 1'h0, med_loop);
    chk1("rx isolate", 1'h1, rx_iso);
    chk("host rx loop", 16'h001a, 16'(host_rx));
    chk("line tx loop", 16'h0000, 16'(line_tx));
    chk1("loop duplex", 1'h1, full_duplex);
    medium_loopback = 1'h0;
    // Restart is a single pulse and reads back as zero
    wr(16'h0200, 1'h0);
    chk("restarts", 16'h0001, 16'(n_restart));
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h0000);
    // Soft reset restores defaults, then accesses work again
    wr(16'h8000, 1'h0);
    chk("srst cycles", 16'(SOFT_RESET_CYCLES), 16'(n_srst));
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h3180);
    // Frames for another PHY or another register
    host.xfer(1'h0, 5'h02, CTRL_REG_ADDR, 16'h0800, 1'h0, rd_v);
    settle();
    rd(PHY_ADDR, CTRL_REG_ADDR, 16'h3180);
    rd(5'h02, CTRL_REG_ADDR, 16'hffff);
    rd(PHY_ADDR, 5'h01, 16'h0000);
    print_verdict();
  end
endmodule

`default_nettype wire
